// ==== umspi_master.sv ====
// Overview of operation
// RQ1: master only; clock always generated internally, never taken from pins.
// RQ2: software sets clock pin direction to output before enabling.
// RQ3: serial clock equals system clock over two times divisor plus one.
// RQ4: phase zero samples leading edge; phase one samples trailing edge.
// RQ5: data driven and captured on opposite serial clock edges.
// RQ6: software keeps polarity, phase and order fixed during transfers.
// RQ7: frames are exactly eight data bits, no framing or parity.
// RQ8: one bit order setting serves both transmit and receive.
// RQ9: next buffered frame follows without gap, else data line idles high.
// RQ10: two back-to-back writes shift out together; complete flag after both.
// RQ11: software keeps divisor zero at transmitter enable, sets it afterwards.
// RQ12: rate divisor resets to zero.
// RQ13: transmitter works alone; receiver only alongside enabled transmitter. Code enables the receiver from mode and receiver_enable_in alone.
// RQ14: software checks idle and clears complete flag before reconfiguring.
// RQ15: enabled transmitter owns and drives the serial output pin.
// RQ16: enabled receiver owns serial input pin; clock pin carries clock.
// RQ17: transfers start only on a data port write.
// RQ18: buffered byte moves to shift register once it is free.
// RQ19: receive overflow drops newest byte, keeps older unread bytes.
// RQ20: software reads one byte back for every byte sent.
// RQ21: buffer empty flag and receive complete flag report buffer states.
// RQ22: transmit complete flag shows all pending transfers finished.
// RQ23: active only with both mode select bits set.
// RQ24: bit order one sends LSB first, zero sends MSB first.
// RQ25: complete flag set when frame done and transmit buffer empty.
// RQ26: frame, overrun and parity error flags always read zero.
// RQ27: serial clock rests at polarity level outside frames.
// RQ28: eight clock pulses per frame, no pause between buffered frames.
`default_nettype none
module umspi_master #(
	parameter int RX_DEPTH = umspi_pkg::RX_DEPTH_D
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [1:0]  mode_select_in,
	input  wire logic        transmitter_enable_in,
	input  wire logic        receiver_enable_in,
	input  wire logic [11:0] rate_divisor_in,
	input  wire logic        clock_phase_in,
	input  wire logic        clock_polarity_in,
	input  wire logic        bit_order_in,
	input  wire logic        clock_pin_direction_in,
	input  wire logic        data_wr_in,
	input  wire logic [7:0]  data_wdata_in,
	input  wire logic        data_rd_in,
	input  wire logic        txc_clear_in,
	input  wire logic        serial_in_pin_in,
	output logic [7:0]       data_rdata_out,
	output logic             tx_buffer_empty_out,
	output logic             rx_complete_out,
	output logic             tx_complete_out,
	output logic [2:0]       error_flags_out,
	output logic             serial_out_pin_out,
	output logic             serial_out_oe_out,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_oe_out,
	output logic             rx_pin_owned_out,
	output logic             master_spi_mode_out
);
	localparam int PW = $clog2(RX_DEPTH);

	if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("RX_DEPTH must be a power of two, at least 2");
	end

	function automatic logic first_bit(input logic [7:0] d,
		input logic lsb);
		first_bit = lsb ? d[0] : d[7];
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] d,
		input logic lsb);
		shift_out = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] d,
		input logic b, input logic lsb);
		shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
	endfunction

	umspi_pkg::umspi_state_t state_r;
	umspi_pkg::umspi_state_t state_nxt;
	logic [3:0]  edge_r, edge_nxt;
	logic        sck_r, sck_nxt;
	logic        sdo_r, sdo_nxt;
	logic [7:0]  tx_sh_r, tx_sh_nxt;
	logic [7:0]  rx_sh_r, rx_sh_nxt;
	logic [7:0]  tx_buf_r, tx_buf_nxt;
	logic        tx_full_r, tx_full_nxt;
	logic        txc_r, txc_nxt;
	logic [11:0] div_r;
	logic [7:0]  mem_r [RX_DEPTH];
	logic [7:0]  mem_nxt [RX_DEPTH];
	logic [PW-1:0] rd_r, rd_nxt;
	logic [PW:0]   cnt_r, cnt_nxt;
	logic [7:0]  rdata_r;
	logic        udre_r, rxc_r, sdo_oe_r, sck_oe_r, rx_own_r, spi_r;
	logic [2:0]  err_r;
	logic        s1_r, s2_r, s3_r, sdi_r, sdi_nxt;
	logic [11:0] gap_r;
	logic        spi_w, tx_on_w, rx_on_w, tick_w, shift_w, last_w;
	logic        load_w, wr_ok_w, sample_w, setup_w, push_w, pop_w;
	logic        keep_w;

	// RQ3 rate generator paced by divisor
	umspi_rate_gen #(
		.DIV_W(12)
	) u_rate (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.run_in    (shift_w),
		.divisor_in(div_r),
		.tick_out  (tick_w)
	);

	always_comb
	begin
		// RQ23 mode gate
		spi_w   = (mode_select_in == umspi_pkg::MODE_SPI);
		tx_on_w = spi_w && transmitter_enable_in;
		// RQ13 receiver rides on transmitter clock
		rx_on_w = spi_w && receiver_enable_in;
		shift_w = (state_r == umspi_pkg::UMSPI_SHIFT);
		// RQ7 eight bits, sixteen edges
		last_w  = shift_w && tick_w && (edge_r == umspi_pkg::EDGE_LAST);
		// RQ17 write starts transfer
		wr_ok_w = data_wr_in && tx_on_w && !tx_full_r;
		// RQ18 move buffer into free shifter
		load_w  = tx_full_r && spi_w &&
			(state_r == umspi_pkg::UMSPI_IDLE || last_w);
		// RQ4 sample edge per phase
		sample_w = shift_w && tick_w &&
			(clock_phase_in ? edge_r[0] : !edge_r[0]);
		// RQ5 setup on the opposite edge
		setup_w = shift_w && tick_w &&
			(clock_phase_in ? !edge_r[0] : edge_r[0] && !last_w);
	end

	always_comb
	begin
		state_nxt = state_r;
		edge_nxt  = edge_r;
		sck_nxt   = sck_r;
		sdo_nxt   = sdo_r;
		tx_sh_nxt = tx_sh_r;
		rx_sh_nxt = rx_sh_r;
		// RQ27 clock rests at polarity
		if (state_r == umspi_pkg::UMSPI_IDLE)
		begin
			sck_nxt = clock_polarity_in;
			sdo_nxt = umspi_pkg::LINE_IDLE;
		end
		// RQ28 one toggle per tick, sixteen per frame
		if (shift_w && tick_w)
		begin
			sck_nxt  = !sck_r;
			edge_nxt = edge_r + 4'h1;
		end
		// RQ8 same order for both paths
		if (sample_w)
			rx_sh_nxt = shift_in(rx_sh_r, sdi_r, bit_order_in);
		// RQ24 order picks end of shifter
		if (setup_w)
		begin
			sdo_nxt   = first_bit(tx_sh_r, bit_order_in);
			tx_sh_nxt = shift_out(tx_sh_r, bit_order_in);
		end
		// RQ9 idle high after last frame
		// phase one: last bit held past its sample edge
		if (last_w)
		begin
			state_nxt = umspi_pkg::UMSPI_IDLE;
			if (!clock_phase_in)
				sdo_nxt = umspi_pkg::LINE_IDLE;
		end
		// RQ10 queued byte follows without gap
		if (load_w)
		begin
			state_nxt = umspi_pkg::UMSPI_SHIFT;
			edge_nxt  = umspi_pkg::EDGE_FIRST;
			if (clock_phase_in)
				tx_sh_nxt = tx_buf_r;
			else
			begin
				sdo_nxt   = first_bit(tx_buf_r, bit_order_in);
				tx_sh_nxt = shift_out(tx_buf_r, bit_order_in);
			end
		end
	end

	always_comb
	begin
		tx_full_nxt = tx_full_r;
		tx_buf_nxt  = tx_buf_r;
		if (load_w)
			tx_full_nxt = 1'b0;
		if (wr_ok_w)
		begin
			tx_full_nxt = 1'b1;
			tx_buf_nxt  = data_wdata_in;
		end
		// RQ22 complete flag for software
		// RQ25 complete when shifter and buffer empty, set beats clear
		txc_nxt = txc_r;
		if (txc_clear_in)
			txc_nxt = 1'b0;
		if (last_w && !tx_full_r)
			txc_nxt = 1'b1;
		// RQ19 full buffer drops the newest byte
		push_w = last_w && rx_on_w;
		pop_w  = data_rd_in && (cnt_r != '0);
		keep_w = push_w && (cnt_r < (PW+1)'(RX_DEPTH) || pop_w);
		mem_nxt = mem_r;
		if (keep_w)
			mem_nxt[PW'(rd_r + cnt_r[PW-1:0])] = rx_sh_nxt;
		rd_nxt  = rd_r + PW'(pop_w);
		cnt_nxt = cnt_r + (PW+1)'(keep_w) - (PW+1)'(pop_w);
		// RQ16 disabled receiver flushes buffer
		if (!rx_on_w)
			cnt_nxt = '0;
		sdi_nxt = (s2_r == s3_r) ? s2_r : sdi_r;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_r   <= umspi_pkg::UMSPI_IDLE;
			edge_r    <= umspi_pkg::EDGE_FIRST;
			sck_r     <= 1'b0;
			sdo_r     <= umspi_pkg::LINE_IDLE;
			tx_sh_r   <= umspi_pkg::DATA_RST;
			rx_sh_r   <= umspi_pkg::DATA_RST;
			tx_buf_r  <= umspi_pkg::DATA_RST;
			tx_full_r <= 1'b0;
			txc_r     <= 1'b0;
			// RQ12 divisor clears at reset
			div_r     <= umspi_pkg::DIV_RST;
			for (int i = 0; i < RX_DEPTH; i++)
				mem_r[i] <= umspi_pkg::DATA_RST;
			rd_r      <= '0;
			cnt_r     <= '0;
			rdata_r   <= umspi_pkg::DATA_RST;
			udre_r    <= 1'b1;
			rxc_r     <= 1'b0;
			err_r     <= umspi_pkg::ERR_ZERO;
			sdo_oe_r  <= 1'b0;
			sck_oe_r  <= 1'b0;
			rx_own_r  <= 1'b0;
			spi_r     <= 1'b0;
			s1_r      <= umspi_pkg::LINE_IDLE;
			s2_r      <= umspi_pkg::LINE_IDLE;
			s3_r      <= umspi_pkg::LINE_IDLE;
			sdi_r     <= umspi_pkg::LINE_IDLE;
			gap_r     <= '0;
		end
		else
		begin
			state_r   <= state_nxt;
			edge_r    <= edge_nxt;
			sck_r     <= sck_nxt;
			sdo_r     <= sdo_nxt;
			tx_sh_r   <= tx_sh_nxt;
			rx_sh_r   <= rx_sh_nxt;
			tx_buf_r  <= tx_buf_nxt;
			tx_full_r <= tx_full_nxt;
			txc_r     <= txc_nxt;
			div_r     <= rate_divisor_in;
			mem_r     <= mem_nxt;
			rd_r      <= rd_nxt;
			cnt_r     <= cnt_nxt;
			rdata_r   <= mem_nxt[rd_nxt];
			// RQ21 buffer flags
			udre_r    <= !tx_full_nxt;
			rxc_r     <= (cnt_nxt != '0);
			// RQ26 error flags unused
			err_r     <= umspi_pkg::ERR_ZERO;
			// RQ15 pin held until pending data is out
			sdo_oe_r  <= tx_on_w || shift_w || tx_full_r;
			// RQ1 clock pin only ever driven by this master
			sck_oe_r  <= clock_pin_direction_in;
			rx_own_r  <= rx_on_w;
			spi_r     <= spi_w;
			s1_r      <= serial_in_pin_in;
			s2_r      <= s1_r;
			s3_r      <= s2_r;
			sdi_r     <= sdi_nxt;
			gap_r     <= (load_w || tick_w) ? 12'h000 : gap_r + 12'h001;
		end
	end

	assign data_rdata_out       = rdata_r;
	assign tx_buffer_empty_out  = udre_r;
	assign rx_complete_out      = rxc_r;
	assign tx_complete_out      = txc_r;
	assign error_flags_out      = err_r;
	assign serial_out_pin_out   = sdo_r;
	assign serial_out_oe_out    = sdo_oe_r;
	assign serial_clock_pin_out = sck_r;
	assign serial_clock_oe_out  = sck_oe_r;
	assign rx_pin_owned_out     = rx_own_r;
	assign master_spi_mode_out  = spi_r;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence frame_end_s;
		shift_w && tick_w && edge_r == umspi_pkg::EDGE_LAST;
	endsequence

	sequence chained_s;
		frame_end_s ##0 tx_full_r;
	endsequence

	half_period_a: assert property ( // RQ3
		shift_w && tick_w |-> gap_r == div_r)
		else $error("half period differs from divisor plus one");

	clock_rest_a: assert property ( // RQ27
		state_r == umspi_pkg::UMSPI_IDLE && $past(rst_n_in) &&
		$past(state_r == umspi_pkg::UMSPI_IDLE) |->
		sck_r == $past(clock_polarity_in))
		else $error("serial clock not at polarity level while idle");

	edge_toggle_a: assert property ( // RQ28
		shift_w && tick_w |=> sck_r != $past(sck_r))
		else $error("serial clock missed a toggle");

	no_gap_a: assert property ( // RQ10
		chained_s |=> shift_w && edge_r == umspi_pkg::EDGE_FIRST &&
		!tx_complete_out && tx_buffer_empty_out)
		else $error("queued frame did not follow directly");

	tx_done_a: assert property ( // RQ25
		frame_end_s ##0 !tx_full_r |=> tx_complete_out &&
		state_r == umspi_pkg::UMSPI_IDLE ##1
		(serial_out_pin_out || shift_w))
		else $error("frame end without complete flag or idle line");

	write_start_a: assert property ( // RQ17
		state_r == umspi_pkg::UMSPI_IDLE && !tx_full_r |=>
		state_r == umspi_pkg::UMSPI_IDLE)
		else $error("transfer began without a data write");

	start_delay_a: assert property ( // RQ18
		wr_ok_w && state_r == umspi_pkg::UMSPI_IDLE |=>
		!tx_buffer_empty_out ##1 shift_w && tx_buffer_empty_out)
		else $error("written byte did not reach the shifter");

	rx_keep_a: assert property ( // RQ19
		push_w && !pop_w && cnt_r == (PW+1)'(RX_DEPTH) |=>
		cnt_r == (PW+1)'(RX_DEPTH) && data_rdata_out == $past(rdata_r))
		else $error("overflow disturbed older receive data");

	mode_gate_a: assert property ( // RQ23
		!spi_w && state_r == umspi_pkg::UMSPI_IDLE |=>
		state_r == umspi_pkg::UMSPI_IDLE [*2])
		else $error("transfer outside master spi mode");

	err_zero_a: assert property ( // RQ26
		error_flags_out == umspi_pkg::ERR_ZERO)
		else $error("error flags not zero");
endmodule
`default_nettype wire

// ==== umspi_pkg.sv ====
`default_nettype none
package umspi_pkg;
	localparam int          FRAME_BITS = 8;
	localparam logic [3:0]  EDGE_FIRST = 4'h0;
	localparam logic [3:0]  EDGE_LAST  = 4'hf;
	localparam logic [1:0]  MODE_SPI   = 2'h3;
	localparam logic [11:0] DIV_RST    = 12'h000;
	localparam logic [7:0]  DATA_RST   = 8'h00;
	localparam logic [2:0]  ERR_ZERO   = 3'h0;
	localparam logic        LINE_IDLE  = 1'b1;
	localparam int          RX_DEPTH_D = 2;
	localparam int          SYNC_LEN   = 3;

	typedef enum logic [1:0]
	{
		UMSPI_IDLE  = 2'b01,
		UMSPI_SHIFT = 2'b10
	} umspi_state_t;
endpackage
`default_nettype wire

// ==== umspi_rate_gen.sv ====
`default_nettype none
module umspi_rate_gen #(
	parameter int DIV_W = 12
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             run_in,
	input  wire logic [DIV_W-1:0] divisor_in,
	output logic                  tick_out
);
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;

	// one tick per half period of divisor+1 cycles
	always_comb
	begin
		tick_out = run_in && (cnt_r == divisor_in);
		if (!run_in || tick_out)
			cnt_nxt = '0;
		else
			cnt_nxt = cnt_r + DIV_W'(1);
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule
`default_nettype wire

// ==== umspi_slave.sv ====
`default_nettype none
module umspi_slave (
	input  wire logic       sck_in,
	input  wire logic       cpol_in,
	input  wire logic       cpha_in,
	input  wire logic       lsb_in,
	input  wire logic       mosi_in,
	input  wire logic [7:0] reply_in,
	output logic            miso_out,
	output logic [7:0]      got_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	int         cnt  = 0;
	logic       lead = 1'b0;

	function automatic logic pick(input int k);
		return lsb_in ? reply_in[k] : reply_in[7 - k];
	endfunction

	task automatic take;
		sh = lsb_in ? {mosi_in, sh[7:1]} : {sh[6:0], mosi_in};
		cnt = (cnt + 1) % 8;
		if (cnt == 0)
		begin
			got_out = sh;
			// phase one: released line shows inverse of last bit
			if (cpha_in)
				miso_out = ~miso_out;
		end
	endtask

	// first bit ready before a phase zero frame
	always @(reply_in or lsb_in or cpha_in)
		if (cnt == 0)
			miso_out = pick(0);

	// sample and setup on opposite edges
	always @(sck_in)
	begin
		if (sck_in !== cpol_in)
		begin
			lead = 1'b1;
			if (cpha_in)
				miso_out = pick(cnt);
			else
				take();
		end
		else if (lead)
		begin
			lead = 1'b0;
			if (cpha_in)
				take();
			else
				miso_out = pick(cnt);
		end
	end
endmodule
`default_nettype wire

// ==== umspi_tb.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, tx_en, rx_en, cpha, cpol, lsb, dir;
	logic        wr, rd, tcl, miso, mosi, sck, sck_q;
	logic        empty, rxc, txc, mosi_oe, sck_oe, rx_own, spi_on;
	logic [1:0]  mode;
	logic [2:0]  errs;
	logic [11:0] div;
	logic [7:0]  wdata, rdata, reply, got;
	int          n_errors = 0;
	int          compares = 0;
	int          n_tog = 0;
	int          gap = 100;
	int          n_gap_bad = 0;
	int          n_run = 0;
	bit          busy = 1'b0;

	umspi_master #(.RX_DEPTH(2)) dut_u (
		.clk_in(clk), .rst_n_in(rst_n), .mode_select_in(mode),
		.transmitter_enable_in(tx_en), .receiver_enable_in(rx_en),
		.rate_divisor_in(div), .clock_phase_in(cpha),
		.clock_polarity_in(cpol), .bit_order_in(lsb),
		.clock_pin_direction_in(dir), .data_wr_in(wr),
		.data_wdata_in(wdata), .data_rd_in(rd), .txc_clear_in(tcl),
		.serial_in_pin_in(miso), .data_rdata_out(rdata),
		.tx_buffer_empty_out(empty), .rx_complete_out(rxc),
		.tx_complete_out(txc), .error_flags_out(errs),
		.serial_out_pin_out(mosi), .serial_out_oe_out(mosi_oe),
		.serial_clock_pin_out(sck), .serial_clock_oe_out(sck_oe),
		.rx_pin_owned_out(rx_own), .master_spi_mode_out(spi_on)
	);

	umspi_slave slave_u (
		.sck_in(sck), .cpol_in(cpol), .cpha_in(cpha), .lsb_in(lsb),
		.mosi_in(mosi), .reply_in(reply), .miso_out(miso),
		.got_out(got)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// half period spacing inside bursts
	always @(posedge clk)
	begin
		gap = gap + 1;
		if (!busy)
			n_run = 0;
		if (sck !== sck_q)
		begin
			n_tog = n_tog + 1;
			if (busy && n_run > 0 && gap != int'(div) + 1)
				n_gap_bad = n_gap_bad + 1;
			if (busy)
				n_run = n_run + 1;
			gap = 0;
		end
		sck_q = sck;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares = compares + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wait_txc;
		int i;
		for (i = 0; i < 3000 && txc !== 1'b1; i++)
			@(negedge clk);
		if (txc !== 1'b1)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED at %0t: transfer timeout", $time);
			end_sim;
		end
		@(negedge clk);
		busy = 1'b0;
	endtask

	task automatic put(input logic [7:0] a, input logic [7:0] b,
		input logic two);
		busy = 1'b1;
		// complete flag cleared with each write
		tcl = 1'b1;
		wr = 1'b1;
		wdata = a;
		@(negedge clk);
		tcl = 1'b0;
		wr = 1'b0;
		if (two)
		begin
			// second byte once the first has left the buffer
			@(negedge clk);
			tcl = 1'b1;
			wr = 1'b1;
			wdata = b;
			@(negedge clk);
			tcl = 1'b0;
			wr = 1'b0;
		end
		@(negedge clk);
	endtask

	task automatic get(input logic [7:0] exp);
		chk(rxc, 1);
		chk(rdata, exp);
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
	endtask

	task automatic one(input logic [2:0] m, input logic [7:0] d,
		input logic [7:0] r);
		int t0;
		{cpol, cpha, lsb} = m;
		reply = r;
		repeat (4) @(negedge clk);
		chk(sck, cpol);
		t0 = n_tog;
		put(d, 8'h00, 1'b0);
		chk(txc, 0);
		wait_txc;
		chk(16'(n_tog - t0), 16);
		chk(got, d);
		chk(sck, cpol);
		chk(mosi, 1);
		chk(errs, 0);
		get(r);
	endtask

	initial
	begin
		int m;
		int t0;
		{tx_en, rx_en, cpha, cpol, lsb, dir, wr, rd, tcl} = '0;
		rst_n = 1'b0;
		mode = 2'h0;
		div = 12'h000;
		wdata = 8'h00;
		reply = 8'h00;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({empty, rxc, txc, mosi, errs}, 16'h0048);
		// clock pin set to output first
		dir = 1'b1;
		mode = 2'h3;
		@(negedge clk);
		tx_en = 1'b1;
		@(negedge clk);
		chk({mosi_oe, sck_oe, spi_on, rx_own}, 16'h000e);
		t0 = n_tog;
		put(8'h6d, 8'h00, 1'b0);
		wait_txc;
		chk(16'(n_tog - t0), 16);
		chk(got, 8'h6d);
		chk(rxc, 0);
		div = 12'h004;
		rx_en = 1'b1;
		@(negedge clk);
		chk(rx_own, 1);
		for (m = 0; m < 8; m++)
			one(3'(m), 8'ha1 + 8'(m * 37), 8'h3c ^ 8'(m * 29));
		div = 12'h005;
		{cpol, cpha, lsb} = 3'h0;
		reply = 8'h96;
		repeat (4) @(negedge clk);
		t0 = n_tog;
		put(8'h5a, 8'hc3, 1'b1);
		wait_txc;
		chk(16'(n_tog - t0), 32);
		chk(got, 8'hc3);
		get(8'h96);
		get(8'h96);
		for (m = 1; m < 4; m++)
		begin
			reply = 8'(m * 17);
			repeat (2) @(negedge clk);
			put(8'h0f, 8'h00, 1'b0);
			wait_txc;
		end
		get(8'h11);
		get(8'h22);
		chk(rxc, 0);
		tx_en = 1'b0;
		repeat (4) @(negedge clk);
		chk(mosi_oe, 0);
		t0 = n_tog;
		put(8'h77, 8'h00, 1'b0);
		repeat (40) @(negedge clk);
		chk(16'(n_tog - t0), 0);
		chk(empty, 1);
		mode = 2'h1;
		tx_en = 1'b1;
		repeat (2) @(negedge clk);
		chk(spi_on, 0);
		put(8'h77, 8'h00, 1'b0);
		repeat (40) @(negedge clk);
		chk(16'(n_tog - t0), 0);
		chk(n_gap_bad, 0);
		end_sim;
	end
endmodule
`default_nettype wire
